// ==== verilog/pio_port_io.sv ====
// General-purpose port I/O: latches, modes, crossbar bypass and pin compare
//
// Operation
// - Cleared digital-select bit makes pin analog
// - Drive bit selects open-drain or push-pull
// - Bypass bit makes crossbar skip the pin
// - Masked pins differing from compare raise event
// - Cleared enable bit excludes pin from compare
// - Latch value drives pins, open-drain high floats
// - Ports 1-3 read pins; analog reads zero
// - Ports 1-3 latches all pages, bit-addressable
// - Port 4 bit 7 reads zero, ignores writes
// - Port 4 reads pins directly, all pages
// - Port 4 drive bits act unconditionally
// - Compare event gives interrupt and wake request
// - Read-modify-write reads latch, not pins
`timescale 1ns/1ps
module pio_port_io
    import pio_pkg::*;
(
    input wire logic CLK_I,
    input wire logic SRST_I,
    input wire logic [7:0] SFR_ADDR_I,
    input wire logic [7:0] SFR_PAGE_I,
    input wire logic SFR_WR_I,
    input wire logic [7:0] SFR_WDATA_I,
    input wire logic SFR_BIT_WR_I,
    input wire logic [2:0] SFR_BIT_IDX_I,
    input wire logic SFR_BIT_VAL_I,
    input wire logic SFR_RD_I,
    input wire logic SFR_RMW_I,
    output logic [7:0] SFR_RDATA_O,
    input wire logic PIN_COMPARE_IRQ_ENABLE_I,
    input wire logic [7:0] P1_PIN_I,
    input wire logic [7:0] P2_PIN_I,
    input wire logic [7:0] P3_PIN_I,
    input wire logic [6:0] P4_PIN_I,
    output logic [7:0] P1_DO_O,
    output logic [7:0] P2_DO_O,
    output logic [7:0] P3_DO_O,
    output logic [6:0] P4_DO_O,
    output logic [7:0] P1_OE_O,
    output logic [7:0] P2_OE_O,
    output logic [7:0] P3_OE_O,
    output logic [6:0] P4_OE_O,
    output logic [7:0] P1_PULLUP_O,
    output logic [7:0] P2_PULLUP_O,
    output logic [7:0] P3_PULLUP_O,
    output logic [7:0] P1_SKIP_O,
    output logic [7:0] P2_SKIP_O,
    output logic [7:0] P3_SKIP_O,
    output logic MATCH_O,
    output logic MATCH_IRQ_O,
    output logic WAKE_O
);
    // ==================================================================
    // State
    logic [7:0] lat_r [4];
    logic [7:0] drv_r [4];
    logic [7:0] dsel_r [3];
    logic [7:0] byp_r [3];
    logic [7:0] cval_r [2];
    logic [7:0] cen_r [2];
    logic [7:0] meta_r [4];
    logic [7:0] sync_r [4];
    logic [7:0] oe_r [4];
    logic [7:0] rdata_r;
    logic match_r;
    logic irq_r;

    // ==================================================================
    // Decode
    wire pg_f = (SFR_PAGE_I == PAGE_F);
    wire pg_0 = (SFR_PAGE_I == PAGE_0);
    wire [7:0] a = SFR_ADDR_I;
    wire s_lat1 = (a == ADDR_PORT1_LATCH);
    wire s_lat2 = (a == ADDR_PORT2_LATCH);
    wire s_lat3 = (a == ADDR_PORT3_LATCH);
    wire s_lat4 = (a == ADDR_PORT4_LATCH);
    wire s_drv1 = pg_f && (a == ADDR_PORT1_DRIVE);
    wire s_drv2 = pg_f && (a == ADDR_PORT2_DRIVE);
    wire s_drv3 = pg_f && (a == ADDR_PORT3_DRIVE);
    wire s_drv4 = pg_f && (a == ADDR_PORT4_DRIVE);
    wire s_byp1 = pg_f && (a == ADDR_PORT1_BYPASS);
    wire s_byp2 = pg_f && (a == ADDR_PORT2_BYPASS);
    wire s_byp3 = pg_f && (a == ADDR_PORT3_BYPASS);
    wire s_dsel1 = pg_f && (a == ADDR_PORT1_DSEL);
    wire s_dsel2 = pg_f && (a == ADDR_PORT2_DSEL);
    wire s_dsel3 = pg_f && (a == ADDR_PORT3_DSEL);
    wire s_cval1 = pg_0 && (a == ADDR_PORT1_CVAL);
    wire s_cen1 = pg_0 && (a == ADDR_PORT1_CEN);
    wire s_cval2 = pg_0 && (a == ADDR_PORT2_CVAL);
    wire s_cen2 = pg_0 && (a == ADDR_PORT2_CEN);

    // Single-bit writes only reach the bit-addressable latches
    wire [7:0] bit_sel = 8'h01 << SFR_BIT_IDX_I;
    wire [7:0] bit_data = SFR_BIT_VAL_I ? 8'hff : 8'h00;
    wire [7:0] lat1_bit = (lat_r[0] & ~bit_sel) | (bit_data & bit_sel);
    wire [7:0] lat2_bit = (lat_r[1] & ~bit_sel) | (bit_data & bit_sel);
    wire [7:0] lat3_bit = (lat_r[2] & ~bit_sel) | (bit_data & bit_sel);
    wire bw = SFR_BIT_WR_I && !SFR_WR_I;
    wire wr = SFR_WR_I;

    // ==================================================================
    // Pin view: analog pins have their receiver off
    wire [7:0] pin1 = sync_r[0] & dsel_r[0];
    wire [7:0] pin2 = sync_r[1] & dsel_r[1];
    wire [7:0] pin3 = sync_r[2] & dsel_r[2];
    wire [7:0] pin4 = sync_r[3] & PORT4_VALID;

    // Plain reads return pins, read-modify-write returns latches
    wire [7:0] rd1 = SFR_RMW_I ? lat_r[0] : pin1;
    wire [7:0] rd2 = SFR_RMW_I ? lat_r[1] : pin2;
    wire [7:0] rd3 = SFR_RMW_I ? lat_r[2] : pin3;
    wire [7:0] rd4 = SFR_RMW_I ? lat_r[3] : pin4;
    wire [7:0] rdata_nxt =
        s_lat1 ? rd1 : s_lat2 ? rd2 : s_lat3 ? rd3 : s_lat4 ? rd4 :
        s_drv1 ? drv_r[0] : s_drv2 ? drv_r[1] : s_drv3 ? drv_r[2] : s_drv4 ? drv_r[3] :
        s_byp1 ? byp_r[0] : s_byp2 ? byp_r[1] : s_byp3 ? byp_r[2] :
        s_dsel1 ? dsel_r[0] : s_dsel2 ? dsel_r[1] : s_dsel3 ? dsel_r[2] :
        s_cval1 ? cval_r[0] : s_cen1 ? cen_r[0] :
        s_cval2 ? cval_r[1] : s_cen2 ? cen_r[1] : 8'h00;

    // ==================================================================
    // Compare and drive
    wire match_nxt = (|((sync_r[0] ^ cval_r[0]) & cen_r[0])) ||
                     (|((sync_r[1] ^ cval_r[1]) & cen_r[1]));
    logic [7:0] oe_nxt [4];
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_port
            // Analog pin never drives; drive mode ignored there
            assign oe_nxt[g] = dsel_r[g] & (drv_r[g] | ~lat_r[g]);
        end
    endgenerate
    assign oe_nxt[3] = (drv_r[3] | ~lat_r[3]) & PORT4_VALID;

    // ==================================================================
    // Registers
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            lat_r <= '{RST_LATCH, RST_LATCH, RST_LATCH, RST_PORT4_LATCH};
            drv_r <= '{RST_DRIVE, RST_DRIVE, RST_DRIVE, RST_DRIVE};
            dsel_r <= '{RST_DSEL, RST_DSEL, RST_DSEL};
            byp_r <= '{RST_BYPASS, RST_BYPASS, RST_BYPASS};
            cval_r <= '{RST_CVAL, RST_CVAL};
            cen_r <= '{RST_CEN, RST_CEN};
        end else begin
            if (wr && s_lat1) lat_r[0] <= SFR_WDATA_I;
            else if (bw && s_lat1) lat_r[0] <= lat1_bit;
            if (wr && s_lat2) lat_r[1] <= SFR_WDATA_I;
            else if (bw && s_lat2) lat_r[1] <= lat2_bit;
            if (wr && s_lat3) lat_r[2] <= SFR_WDATA_I;
            else if (bw && s_lat3) lat_r[2] <= lat3_bit;
            if (wr && s_lat4) lat_r[3] <= SFR_WDATA_I & PORT4_VALID;
            if (wr && s_drv1) drv_r[0] <= SFR_WDATA_I;
            if (wr && s_drv2) drv_r[1] <= SFR_WDATA_I;
            if (wr && s_drv3) drv_r[2] <= SFR_WDATA_I;
            if (wr && s_drv4) drv_r[3] <= SFR_WDATA_I & PORT4_VALID;
            if (wr && s_byp1) byp_r[0] <= SFR_WDATA_I;
            if (wr && s_byp2) byp_r[1] <= SFR_WDATA_I;
            if (wr && s_byp3) byp_r[2] <= SFR_WDATA_I;
            if (wr && s_dsel1) dsel_r[0] <= SFR_WDATA_I;
            if (wr && s_dsel2) dsel_r[1] <= SFR_WDATA_I;
            if (wr && s_dsel3) dsel_r[2] <= SFR_WDATA_I;
            if (wr && s_cval1) cval_r[0] <= SFR_WDATA_I;
            if (wr && s_cen1) cen_r[0] <= SFR_WDATA_I;
            if (wr && s_cval2) cval_r[1] <= SFR_WDATA_I;
            if (wr && s_cen2) cen_r[1] <= SFR_WDATA_I;
        end
    end

    // Two-stage synchroniser; first stage feeds only the second
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            meta_r <= '{8'h00, 8'h00, 8'h00, 8'h00};
            sync_r <= '{8'h00, 8'h00, 8'h00, 8'h00};
        end else begin
            meta_r <= '{P1_PIN_I, P2_PIN_I, P3_PIN_I, {1'b0, P4_PIN_I}};
            sync_r <= meta_r;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            oe_r <= '{8'h00, 8'h00, 8'h00, 8'h00};
            rdata_r <= 8'h00;
            match_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            oe_r <= oe_nxt;
            if (SFR_RD_I) rdata_r <= rdata_nxt;
            match_r <= match_nxt;
            irq_r <= match_nxt && PIN_COMPARE_IRQ_ENABLE_I;
        end
    end

    // ==================================================================
    // Outputs
    assign SFR_RDATA_O = rdata_r;
    assign P1_DO_O = lat_r[0];
    assign P2_DO_O = lat_r[1];
    assign P3_DO_O = lat_r[2];
    assign P4_DO_O = lat_r[3][6:0];
    assign P1_OE_O = oe_r[0];
    assign P2_OE_O = oe_r[1];
    assign P3_OE_O = oe_r[2];
    assign P4_OE_O = oe_r[3][6:0];
    assign P1_PULLUP_O = dsel_r[0];
    assign P2_PULLUP_O = dsel_r[1];
    assign P3_PULLUP_O = dsel_r[2];
    assign P1_SKIP_O = byp_r[0];
    assign P2_SKIP_O = byp_r[1];
    assign P3_SKIP_O = byp_r[2];
    assign MATCH_O = match_r;
    assign MATCH_IRQ_O = irq_r;
    // Wake follows the event level, not the interrupt enable
    assign WAKE_O = match_r;

    // ==================================================================
    // Checks
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (SRST_I);

    chk_analog_no_drive: assert property ((P1_OE_O & ~$past(dsel_r[0])) == 8'h00)
        else $error("analog pin on port 1 is driven");
    chk_open_drain_float: assert property ((P2_OE_O & $past(lat_r[1] & ~drv_r[1])) == 8'h00)
        else $error("open-drain high pin on port 2 is driven");
    chk_push_pull_drive: assert property ((~P3_OE_O & $past(dsel_r[2] & drv_r[2])) == 8'h00)
        else $error("push-pull digital pin on port 3 not driven");
    chk_port4_drive: assert property (P4_OE_O == $past(drv_r[3][6:0] | ~lat_r[3][6:0]))
        else $error("port 4 drive enable wrong");
    chk_match_pins: assert property (
        MATCH_O == $past(|((meta_r[0] ^ cval_r[0]) & cen_r[0]) || |((meta_r[1] ^ cval_r[1]) & cen_r[1]), 2)
        || $past(SRST_I, 2) || $past(SRST_I) || $changed(cen_r[0]) || $changed(cval_r[0])
        || $changed(cen_r[1]) || $changed(cval_r[1])
        || $past($changed(cen_r[0]) || $changed(cval_r[0]) || $changed(cen_r[1]) || $changed(cval_r[1])))
        else $error("compare event does not follow synchronised pins");
    chk_mask_off_no_event: assert property ((cen_r[0] == 8'h00 && cen_r[1] == 8'h00)[*2] |=> !MATCH_O)
        else $error("compare event with all pins excluded");
    chk_irq_gated: assert property (MATCH_IRQ_O |-> MATCH_O && $past(PIN_COMPARE_IRQ_ENABLE_I))
        else $error("interrupt without enabled event");
    chk_analog_read_zero: assert property (SFR_RD_I && !SFR_RMW_I && s_lat1 |=> (SFR_RDATA_O & ~$past(dsel_r[0])) == 8'h00)
        else $error("analog pin on port 1 read as one");
    chk_rmw_reads_latch: assert property (SFR_RD_I && SFR_RMW_I && s_lat2 |=> SFR_RDATA_O == $past(lat_r[1]))
        else $error("read-modify-write did not return latch");
    chk_port4_top_zero: assert property (SFR_RD_I && (s_lat4 || s_drv4) |=> !SFR_RDATA_O[7])
        else $error("port 4 bit 7 read as one");

    // ==================================================================
    // Drive, pullup and bypass checks
    // Port 1 enable must track mode, drive and latch one cycle late
    chk_port1_enable: assert property (
        P1_OE_O == $past(dsel_r[0] & (drv_r[0] | ~lat_r[0])))
        else $error("port 1 drive enable wrong");
    chk_analog_no_pullup: assert property (
        (P2_PULLUP_O & ~dsel_r[1]) == 8'h00)
        else $error("analog pin on port 2 keeps its pullup");
    chk_bypass_write: assert property (
        wr && s_byp2 |=> P2_SKIP_O == $past(SFR_WDATA_I))
        else $error("port 2 bypass write lost");
    // Wrong page must not reach the drive register
    chk_wrong_page_drive: assert property (
        wr && pg_0 && (a == ADDR_PORT3_DRIVE) |=> $stable(drv_r[2]))
        else $error("drive register written from wrong page");

    // ==================================================================
    // Latch and read checks
    chk_latch_write: assert property (
        wr && s_lat3 |=> P3_DO_O == $past(SFR_WDATA_I))
        else $error("port 3 latch write lost");
    chk_bit_write: assert property (
        bw && s_lat1 |=> P1_DO_O[$past(SFR_BIT_IDX_I)] == $past(SFR_BIT_VAL_I))
        else $error("port 1 single-bit write lost");
    chk_port3_analog_read: assert property (
        SFR_RD_I && !SFR_RMW_I && s_lat3 |=> (SFR_RDATA_O & ~$past(dsel_r[2])) == 8'h00)
        else $error("analog pin on port 3 read as one");
    // Port 4 has no analog select, so a read is the pins themselves
    chk_port4_read: assert property (
        SFR_RD_I && !SFR_RMW_I && s_lat4 |=> SFR_RDATA_O == {1'b0, $past(sync_r[3][6:0])})
        else $error("port 4 read does not return pins");
    chk_port4_top_bits: assert property (
        !lat_r[3][7] && !drv_r[3][7])
        else $error("port 4 bit 7 stored");

    // ==================================================================
    // Compare and synchroniser checks
    chk_irq_follows: assert property (
        MATCH_O && $past(PIN_COMPARE_IRQ_ENABLE_I) |-> MATCH_IRQ_O)
        else $error("enabled compare event gave no interrupt");
    chk_match_after_reset: assert property (
        $past(SRST_I) |-> !MATCH_O)
        else $error("compare event right after reset");
    // Two flops of latency; a shorter path would risk metastability
    chk_sync_depth: assert property (
        !$past(SRST_I) && !$past(SRST_I, 2) |-> sync_r[2] == $past(P3_PIN_I, 2))
        else $error("port 3 pins not two stages late");

    cov_port4_read: cover property (SFR_RD_I && s_lat4 && !SFR_RMW_I);
    cov_wake_no_irq: cover property (MATCH_O && !PIN_COMPARE_IRQ_ENABLE_I);
    cov_match_irq: cover property (PIN_COMPARE_IRQ_ENABLE_I ##1 MATCH_IRQ_O);
    cov_bit_write: cover property (bw && s_lat1 ##1 P1_DO_O != $past(P1_DO_O));
    cov_analog_read: cover property (SFR_RD_I && s_lat3 && dsel_r[2] != 8'hff);
endmodule : pio_port_io

// ==== verilog/pio_pkg.sv ====
// Register map, pages and reset values of the general-purpose port block
package pio_pkg;
    // ==================================================================
    // Register pages
    localparam logic [7:0] PAGE_0 = 8'h00;
    localparam logic [7:0] PAGE_F = 8'h0f;
    // ==================================================================
    // Register addresses
    localparam logic [7:0] ADDR_PORT1_LATCH = 8'h90;
    localparam logic [7:0] ADDR_PORT2_LATCH = 8'ha0;
    localparam logic [7:0] ADDR_PORT3_LATCH = 8'hb0;
    localparam logic [7:0] ADDR_PORT4_LATCH = 8'hb5;
    localparam logic [7:0] ADDR_PORT1_DRIVE = 8'ha5;
    localparam logic [7:0] ADDR_PORT2_DRIVE = 8'ha6;
    localparam logic [7:0] ADDR_PORT3_DRIVE = 8'haf;
    localparam logic [7:0] ADDR_PORT4_DRIVE = 8'hae;
    localparam logic [7:0] ADDR_PORT1_BYPASS = 8'hd5;
    localparam logic [7:0] ADDR_PORT2_BYPASS = 8'hd6;
    localparam logic [7:0] ADDR_PORT3_BYPASS = 8'hd7;
    localparam logic [7:0] ADDR_PORT1_CVAL = 8'he1;
    localparam logic [7:0] ADDR_PORT1_CEN = 8'he2;
    localparam logic [7:0] ADDR_PORT2_CVAL = 8'hb1;
    localparam logic [7:0] ADDR_PORT2_CEN = 8'hb2;
    localparam logic [7:0] ADDR_PORT1_DSEL = 8'hf2;
    localparam logic [7:0] ADDR_PORT2_DSEL = 8'hf3;
    localparam logic [7:0] ADDR_PORT3_DSEL = 8'hf4;
    // ==================================================================
    // Reset values
    localparam logic [7:0] RST_LATCH = 8'hff;
    localparam logic [7:0] RST_PORT4_LATCH = 8'h7f;
    localparam logic [7:0] RST_DRIVE = 8'h00;
    localparam logic [7:0] RST_BYPASS = 8'h00;
    localparam logic [7:0] RST_CVAL = 8'hff;
    localparam logic [7:0] RST_CEN = 8'h00;
    localparam logic [7:0] RST_DSEL = 8'hff;
    // ==================================================================
    // Port 4 has seven pins only
    localparam logic [7:0] PORT4_VALID = 8'h7f;
endpackage : pio_pkg

// ==== dv/pio_pin_model.sv ====
// Behavioural external circuit hanging on one port's pins
`timescale 1ns/1ps
module pio_pin_model #(
    parameter int W = 8
) (
    input wire logic clk_i,
    input wire logic [W-1:0] do_i,
    input wire logic [W-1:0] oe_i,
    input wire logic [W-1:0] pu_i,
    input wire logic [W-1:0] ext_en_i,
    input wire logic [W-1:0] ext_val_i,
    output logic [W-1:0] pin_o
);
    // ====================
    // Pin resolution
    // Floating pins wander so a stale value never passes for a real one
    logic [W-1:0] wander_r = '0;
    always_ff @(posedge clk_i) begin
        wander_r <= ~wander_r;
    end
    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (oe_i[i]) begin
                pin_o[i] = do_i[i];
            end else if (ext_en_i[i]) begin
                pin_o[i] = ext_val_i[i];
            end else begin
                pin_o[i] = pu_i[i] ? 1'b1 : wander_r[i];
            end
        end
    end
endmodule : pio_pin_model

// ==== dv/tb.sv ====
// Self-checking bench for the general-purpose port block
`timescale 1ns/1ps
module tb;
    import pio_pkg::*;
    // ====================
    // Signals
    logic clk = 0, srst = 1, wr_s = 0, bwr = 0, bval = 0, rd_s = 0, rmw = 0, irq_en = 0;
    logic [7:0] addr = 0, page = 0, wdata = 0, rdata;
    logic [2:0] bidx = 0;
    logic [15:0] lfsr = 16'hed11;
    logic [7:0] ext_en [1:4], ext_v [1:4];
    wire logic [7:0] dout [1:4], oe [1:4], pu [1:3], skip [1:3], pin [1:4];
    wire logic match, irq, wake;
    int bad_count = 0, total_checks = 0, cyc = 0, p;
    localparam logic [7:0] LA [1:4] = '{ADDR_PORT1_LATCH, ADDR_PORT2_LATCH, ADDR_PORT3_LATCH, ADDR_PORT4_LATCH};
    localparam logic [7:0] DA [1:4] = '{ADDR_PORT1_DRIVE, ADDR_PORT2_DRIVE, ADDR_PORT3_DRIVE, ADDR_PORT4_DRIVE};
    localparam logic [7:0] SA [1:3] = '{ADDR_PORT1_DSEL, ADDR_PORT2_DSEL, ADDR_PORT3_DSEL};
    localparam logic [7:0] BA [1:3] = '{ADDR_PORT1_BYPASS, ADDR_PORT2_BYPASS, ADDR_PORT3_BYPASS};
    initial begin
        forever #12.5 clk = ~clk;
    end
    pio_port_io DUT (.CLK_I(clk), .SRST_I(srst), .SFR_ADDR_I(addr), .SFR_PAGE_I(page), .SFR_WR_I(wr_s),
        .SFR_WDATA_I(wdata), .SFR_BIT_WR_I(bwr), .SFR_BIT_IDX_I(bidx), .SFR_BIT_VAL_I(bval), .SFR_RD_I(rd_s),
        .SFR_RMW_I(rmw), .SFR_RDATA_O(rdata), .PIN_COMPARE_IRQ_ENABLE_I(irq_en), .P1_PIN_I(pin[1]),
        .P2_PIN_I(pin[2]), .P3_PIN_I(pin[3]), .P4_PIN_I(pin[4][6:0]), .P1_DO_O(dout[1]), .P2_DO_O(dout[2]),
        .P3_DO_O(dout[3]), .P4_DO_O(dout[4][6:0]), .P1_OE_O(oe[1]), .P2_OE_O(oe[2]), .P3_OE_O(oe[3]),
        .P4_OE_O(oe[4][6:0]), .P1_PULLUP_O(pu[1]), .P2_PULLUP_O(pu[2]), .P3_PULLUP_O(pu[3]),
        .P1_SKIP_O(skip[1]), .P2_SKIP_O(skip[2]), .P3_SKIP_O(skip[3]), .MATCH_O(match),
        .MATCH_IRQ_O(irq), .WAKE_O(wake));
    for (genvar g = 1; g <= 3; g++) begin : g_pin
        pio_pin_model #(.W(8)) u_pin (.clk_i(clk), .do_i(dout[g]), .oe_i(oe[g]), .pu_i(pu[g]),
            .ext_en_i(ext_en[g]), .ext_val_i(ext_v[g]), .pin_o(pin[g]));
    end
    pio_pin_model #(.W(7)) u_pin4 (.clk_i(clk), .do_i(dout[4][6:0]), .oe_i(oe[4][6:0]), .pu_i(7'h00),
        .ext_en_i(ext_en[4][6:0]), .ext_val_i(ext_v[4][6:0]), .pin_o(pin[4][6:0]));
    // ====================
    // Helpers
    function automatic logic [7:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr[7:0];
    endfunction : rnd
    task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [7:0] pg, input logic [7:0] dt);
        @(negedge clk);
        {addr, page, wdata, wr_s} = {a, pg, dt, 1'b1};
        @(negedge clk);
        wr_s = 0;
    endtask : wr
    task bw(input logic [7:0] a, input logic [2:0] i, input logic b);
        @(negedge clk);
        {addr, page, bidx, bval, bwr} = {a, PAGE_0, i, b, 1'b1};
        @(negedge clk);
        bwr = 0;
    endtask : bw
    task rd(input logic [7:0] a, input logic [7:0] pg, input logic r, output logic [7:0] d);
        @(negedge clk);
        {addr, page, rmw, rd_s} = {a, pg, r, 1'b1};
        @(negedge clk);
        rd_s = 0;
        d = rdata;
    endtask : rd
    // Latches are written on page F, read on page 0; others get a wrong-page write
    task regchk(input logic [7:0] a, input logic [7:0] pg, input logic [7:0] rv, input logic [7:0] m,
        input bit xpg);
        logic [7:0] d, v;
        v = rnd();
        rd(a, pg, 1'b1, d);
        chk("reset value", d, rv);
        wr(a, xpg ? pg : PAGE_F, v);
        rd(a, pg, 1'b1, d);
        chk("readback", d, v & m);
        if (xpg) begin
            wr(a, pg ^ 8'h0f, ~v);
            rd(a, pg, 1'b1, d);
            chk("wrong page", d, v & m);
        end
    endtask : regchk
    task close_out;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : close_out
    // Generous ceiling; the sequence needs about 700 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            close_out();
        end
    end
    // ====================
    // Sequence
    initial begin
        logic [7:0] d, v, m, lat, drv, sel, xo;
        for (int i = 1; i <= 4; i++) begin
            {ext_en[i], ext_v[i]} = {8'hff, 8'h00};
        end
        repeat (5) @(negedge clk);
        srst = 0;
        for (int i = 1; i <= 4; i++) begin
            chk("latch out", dout[i] & (i == 4 ? 8'h7f : 8'hff), i == 4 ? 8'h7f : 8'hff);
            regchk(DA[i], PAGE_F, RST_DRIVE, i == 4 ? 8'h7f : 8'hff, 1);
            regchk(LA[i], PAGE_0, i == 4 ? RST_PORT4_LATCH : RST_LATCH, i == 4 ? 8'h7f : 8'hff, 0);
            if (i < 4) begin
                regchk(BA[i], PAGE_F, RST_BYPASS, 8'hff, 1);
                regchk(SA[i], PAGE_F, RST_DSEL, 8'hff, 1);
            end
        end
        regchk(ADDR_PORT1_CVAL, PAGE_0, RST_CVAL, 8'hff, 1);
        regchk(ADDR_PORT1_CEN, PAGE_0, RST_CEN, 8'hff, 1);
        regchk(ADDR_PORT2_CVAL, PAGE_0, RST_CVAL, 8'hff, 1);
        regchk(ADDR_PORT2_CEN, PAGE_0, RST_CEN, 8'hff, 1);
        rd(8'h91, PAGE_0, 1'b0, d);
        chk("unmapped", d, 8'h00);
        // Modes, drive and pin reads; first pass makes ports 1-3 all analog
        for (int k = 0; k < 6; k++) begin
            for (p = 1; p <= 4; p++) begin
                {lat, drv, sel, xo} = {rnd(), rnd(), rnd(), rnd()};
                sel = (p == 4) ? 8'hff : (k == 0) ? 8'h00 : sel;
                m = (p == 4) ? 8'h7f : 8'hff;
                ext_v[p] = xo;
                wr(LA[p], PAGE_0, lat);
                wr(DA[p], PAGE_F, drv);
                if (p < 4) begin
                    wr(SA[p], PAGE_F, sel);
                    wr(BA[p], PAGE_F, ~sel);
                end
                repeat (5) @(negedge clk);
                v = sel & (drv | ~lat) & m;
                chk("output enable", oe[p] & m, v);
                chk("output data", dout[p] & m, lat & m);
                rd(LA[p], PAGE_0, 1'b0, d);
                chk("pin read", d, sel & m & ((v & lat) | (~v & xo)));
                if (p < 4) begin
                    chk("pullup", pu[p], sel);
                    chk("bypass", skip[p], ~sel);
                end
            end
        end
        // Undriven ports 1 and 2 for the compare; pullup alone holds port 1 high
        for (p = 1; p <= 2; p++) begin
            wr(LA[p], PAGE_0, 8'hff);
            wr(DA[p], PAGE_F, 8'h00);
            wr(SA[p], PAGE_F, 8'hff);
        end
        ext_en[1] = 8'h00;
        repeat (5) @(negedge clk);
        rd(LA[1], PAGE_0, 1'b0, d);
        chk("pulled up", d, 8'hff);
        ext_en[1] = 8'hff;
        for (int k = 0; k < 10; k++) begin
            {v, m, lat, drv, xo, d} = {rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
            {m, drv} = (k == 0) ? 16'h0000 : {m, drv};
            {ext_v[1], ext_v[2], irq_en} = k[0] ? {v, lat, xo[0]} : {d, xo, xo[0]};
            wr(ADDR_PORT1_CVAL, PAGE_0, v);
            wr(ADDR_PORT1_CEN, PAGE_0, m);
            wr(ADDR_PORT2_CVAL, PAGE_0, lat);
            wr(ADDR_PORT2_CEN, PAGE_0, drv);
            repeat (4) @(negedge clk);
            sel = {7'h00, ((ext_v[1] & m) != (v & m)) || ((ext_v[2] & drv) != (lat & drv))};
            chk("match", {7'h00, match}, sel);
            chk("match irq", {7'h00, irq}, sel & {7'h00, irq_en});
            chk("wake", {7'h00, wake}, sel);
        end
        // Single-bit writes and read-modify-write reads
        for (p = 1; p <= 3; p++) begin
            v = rnd();
            wr(LA[p], PAGE_0, 8'h00);
            wr(DA[p], PAGE_F, 8'h00);
            wr(SA[p], PAGE_F, 8'hff);
            bw(LA[p], v[2:0], 1'b1);
            repeat (5) @(negedge clk);
            chk("bit write", dout[p], 8'h01 << v[2:0]);
            rd(LA[p], PAGE_0, 1'b1, d);
            chk("rmw read", d, 8'h01 << v[2:0]);
            rd(LA[p], PAGE_0, 1'b0, d);
            chk("pin after bit write", d, ext_v[p] & (8'h01 << v[2:0]));
        end
        wr(LA[4], PAGE_0, 8'h7f);
        bw(LA[4], 3'h0, 1'b0);
        rd(LA[4], PAGE_0, 1'b1, d);
        chk("port 4 bit write", d, 8'h7f);
        close_out();
    end
endmodule : tb
